// ### smspi_core.sv
`timescale 1ns/100ps
module smspi_core
    import smspi_pkg::*;
#(
    parameter int SLEEP_CYCLES = SLEEP_ENTRY_CYCLES,
    parameter int WAKE_CYCLES = WAKE_RECOVERY_CYCLES
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic spiClk,
    input wire logic spiCsN,
    input wire logic spiSi,
    output logic spiSo,
    output logic spiSoEn,
    input wire logic wpN,
    output logic [7:0] statusByte,
    output logic writeEnableLatch,
    output logic sleeping,
    output logic regulatorsOn,
    output logic executeInPlace
);
    // Link domain (serial clock)
    logic [2:0] phase_q;
    logic [2:0] byteCnt_q;
    logic [7:0] shift_q;
    logic [7:0] opcode_q;
    logic [7:0] statNew_q;
    logic [7:0] mode_q;
    logic [2:0] cmdBytes_q;
    // Two-state: the toggle has no reset, yet must start at a known level
    bit cmdToggle_q;
    logic [ADDR_BITS-1:0] addr_q;
    logic [7:0] mem [0:MEM_BYTES-1];
    logic [7:0] outShift_q;
    logic [7:0] bitIn;
    logic byteDone;
    logic isRead;
    logic isFast;
    logic isWrite;
    logic dataPhase;
    logic protHit;
    logic [3:0] linkCtl;
    logic linkAllow;
    logic linkAsleep;
    logic [1:0] linkBp;
    logic [7:0] rdByte;

    // Control levels from the system domain; they only change while chip
    // select is high, and settle within the opcode byte
    logic [3:0] linkCtlSrc;
    smspi_sync #(.WIDTH(4), .RESET_VAL(4'h0)) u_link_sync (
        .clk(spiClk),
        .rst(1'b0),
        .din(linkCtlSrc),
        .dout(linkCtl)
    );
    assign linkAllow = linkCtl[0];
    assign linkAsleep = linkCtl[1];
    assign linkBp = linkCtl[3:2];

    assign bitIn = {shift_q[6:0], spiSi};
    assign byteDone = (phase_q == BIT_LAST);
    assign isRead = (opcode_q == CMD_READ) && !linkAsleep;
    assign isFast = (opcode_q == CMD_FAST_READ) && !linkAsleep;
    assign isWrite = (opcode_q == CMD_WRITE);
    assign dataPhase = ((isRead || isWrite) && byteCnt_q >= BYTE_DATA) ||
        (isFast && byteCnt_q >= BYTE_FAST_DATA);

    // Block protection: upper quarter, upper half or whole array
    always_comb begin
        unique case (linkBp)
            2'h0: protHit = 1'b0;
            2'h1: protHit = (addr_q[ADDR_BITS-1 -: 2] == 2'h3);
            2'h2: protHit = addr_q[ADDR_BITS-1];
            2'h3: protHit = 1'b1;
        endcase
    end

    // Frame position, cleared while chip select is high
    always_ff @(posedge spiClk or posedge spiCsN) begin
        if (spiCsN) begin
            phase_q <= 3'h0;
            byteCnt_q <= 3'h0;
        end else begin
            phase_q <= phase_q + 3'h1;
            if (byteDone && byteCnt_q != BYTE_SAT) begin
                byteCnt_q <= byteCnt_q + 3'h1;
            end
        end
    end

    // Frame capture; held after chip select rises for the system domain
    always_ff @(posedge spiClk) begin
        shift_q <= bitIn;
        if (byteDone) begin
            if (byteCnt_q == BYTE_SAT) begin
                cmdBytes_q <= BYTE_SAT;
            end else begin
                cmdBytes_q <= byteCnt_q + 3'h1;
            end
        end else if (byteCnt_q == BYTE_OPCODE && phase_q == 3'h0) begin
            cmdBytes_q <= 3'h0;
        end
        if (byteDone && byteCnt_q == BYTE_OPCODE) begin
            opcode_q <= bitIn;
            cmdToggle_q <= ~cmdToggle_q;
        end
        if (byteDone && byteCnt_q == BYTE_STATUS) begin
            statNew_q <= bitIn;
        end
        if (byteDone && byteCnt_q == BYTE_MODE) begin
            mode_q <= bitIn;
        end
    end

    // Address: three bytes shifted in, upper seven bits fall off the top
    always_ff @(posedge spiClk) begin
        if (byteDone && byteCnt_q >= BYTE_STATUS &&
            byteCnt_q <= BYTE_ADDR_LAST) begin
            addr_q <= {addr_q[ADDR_BITS-9:0], bitIn};
        end else if (byteDone && dataPhase) begin
            if (addr_q == ADDR_BITS'(MEM_BYTES - 1)) begin
                addr_q <= ADDR_WRAP;
            end else begin
                addr_q <= addr_q + 17'h00001;
            end
        end
    end

    // Array write on the last bit of each data byte, no busy time
    always_ff @(posedge spiClk) begin
        if (byteDone && dataPhase && isWrite && linkAllow && !protHit) begin
            mem[addr_q] <= bitIn;
        end
    end

    assign rdByte = mem[addr_q];

    // Output side on falling edges; nothing moves before the first rising
    // edge, so a mode 3 idle-high clock does not shift out early
    always_ff @(negedge spiClk or posedge spiCsN) begin
        if (spiCsN) begin
            spiSo <= 1'b0;
            spiSoEn <= 1'b0;
            outShift_q <= 8'h00;
        end else if (byteCnt_q != BYTE_OPCODE && phase_q == 3'h0 &&
            dataPhase && !isWrite) begin
            spiSo <= rdByte[7];
            outShift_q <= {rdByte[6:0], 1'b0};
            spiSoEn <= 1'b1;
        end else if (spiSoEn) begin
            spiSo <= outShift_q[7];
            outShift_q <= {outShift_q[6:0], 1'b0};
        end
    end

    // System domain
    logic [2:0] pinSync;
    logic csHigh;
    logic wpHigh;
    logic togSync;
    logic csPrev_q;
    logic togSeen_q;
    logic init_q;
    logic newCmd;
    logic [7:0] cmdOp;
    logic [2:0] cmdLen;
    smspi_pwr_t pwr_q;
    logic [TIMER_BITS-1:0] timer_q;
    logic wel_q;
    logic status_write_disable_bit_q;
    logic [1:0] bp_q;
    logic statusAllowed;

    smspi_sync #(.WIDTH(3), .RESET_VAL(3'h3)) u_sys_sync (
        .clk(sys_clk),
        .rst(sys_rst),
        .din({cmdToggle_q, wpN, spiCsN}),
        .dout(pinSync)
    );
    assign csHigh = pinSync[0];
    assign wpHigh = pinSync[1];
    assign togSync = pinSync[2];

    // Frame registers are static while chip select is high, so reading
    // them after the synchronised rise is safe
    assign cmdOp = opcode_q;
    assign cmdLen = cmdBytes_q;
    assign newCmd = csHigh && !csPrev_q && init_q && (togSync != togSeen_q);
    assign statusAllowed = wel_q && (!status_write_disable_bit_q || wpHigh);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            csPrev_q <= 1'b1;
            togSeen_q <= 1'b0;
            init_q <= 1'b0;
        end else begin
            csPrev_q <= csHigh;
            init_q <= 1'b1;
            // Track the toggle while chip select rests high, so the
            // synchroniser's reset value cannot swallow the next command
            if (!init_q || newCmd || (csHigh && csPrev_q)) begin
                togSeen_q <= togSync;
            end
        end
    end

    // Power state; reset always lands awake
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pwr_q <= PWR_ACTIVE;
            timer_q <= '0;
        end else begin
            unique case (pwr_q)
                PWR_ACTIVE: begin
                    if (newCmd && cmdOp == CMD_SLEEP &&
                        cmdLen == 3'h1) begin
                        pwr_q <= PWR_ENTERING;
                        timer_q <= TIMER_BITS'(SLEEP_CYCLES - 1);
                    end
                end
                PWR_ENTERING: begin
                    if (timer_q == '0) begin
                        pwr_q <= PWR_ASLEEP;
                    end else begin
                        timer_q <= timer_q - 1'b1;
                    end
                end
                PWR_ASLEEP: begin
                    if (newCmd && cmdOp == CMD_WAKE &&
                        cmdLen == 3'h1) begin
                        pwr_q <= PWR_WAKING;
                        timer_q <= TIMER_BITS'(WAKE_CYCLES - 1);
                    end
                end
                PWR_WAKING: begin
                    // Frames during recovery are not expected from the host
                    if (timer_q == '0) begin
                        pwr_q <= PWR_ACTIVE;
                    end else begin
                        timer_q <= timer_q - 1'b1;
                    end
                end
            endcase
        end
    end

    // Latch and status bits; only an awake device executes them
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wel_q <= 1'b0;
            status_write_disable_bit_q <= STATUS_WRITE_DISABLE_BIT_RESET;
            bp_q <= BP_RESET;
            executeInPlace <= 1'b0;
        end else if (newCmd && pwr_q == PWR_ACTIVE) begin
            if (cmdOp == CMD_WRITE_ENABLE && cmdLen >= 3'h1) begin
                wel_q <= 1'b1;
            end
            if (cmdOp == CMD_WRITE_DISABLE && cmdLen >= 3'h1) begin
                wel_q <= 1'b0;
            end
            if (cmdOp == CMD_STATUS_WRITE && cmdLen >= 3'h2 &&
                statusAllowed) begin
                status_write_disable_bit_q <= statNew_q[SR_STATUS_WRITE_DISABLE_BIT];
                bp_q <= {statNew_q[SR_BP1], statNew_q[SR_BP0]};
            end
            if (cmdOp == CMD_FAST_READ && cmdLen >= BYTE_FAST_DATA) begin
                if (mode_q == MODE_XIP_ENTER) begin
                    executeInPlace <= 1'b1;
                end else if (mode_q == MODE_XIP_EXIT) begin
                    executeInPlace <= 1'b0;
                end
            end
        end
    end

    // Levels handed to the link side
    always_comb begin
        linkCtlSrc = {bp_q, (pwr_q != PWR_ACTIVE),
            (wel_q && pwr_q == PWR_ACTIVE)};
    end

    // Registered status outputs
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            statusByte <= 8'h00;
            writeEnableLatch <= 1'b0;
            sleeping <= 1'b0;
            regulatorsOn <= 1'b1;
        end else begin
            statusByte <= {status_write_disable_bit_q, QUAD_MODE_VALUE, 2'h0, bp_q, wel_q,
                1'b0};
            writeEnableLatch <= wel_q;
            sleeping <= (pwr_q == PWR_ASLEEP);
            regulatorsOn <= (pwr_q == PWR_ACTIVE) ||
                (pwr_q == PWR_WAKING);
        end
    end
endmodule

// ### smspi_pkg.sv
package smspi_pkg;
    // Command codes
    localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_FAST_READ = 8'h0B;
    localparam logic [7:0] CMD_SLEEP = 8'hB9;
    localparam logic [7:0] CMD_WAKE = 8'hAB;

    // Fast read mode byte values
    localparam logic [7:0] MODE_XIP_ENTER = 8'hEF;
    localparam logic [7:0] MODE_XIP_EXIT = 8'hFF;

    // Memory organisation
    localparam int ADDR_BITS = 17;
    localparam int MEM_BYTES = 131072;
    localparam logic [ADDR_BITS-1:0] ADDR_WRAP = 17'h00000;

    // Frame layout, counted in whole bytes after chip select falls
    localparam logic [2:0] BYTE_OPCODE = 3'h0;
    localparam logic [2:0] BYTE_STATUS = 3'h1;
    localparam logic [2:0] BYTE_ADDR_LAST = 3'h3;
    localparam logic [2:0] BYTE_MODE = 3'h4;
    localparam logic [2:0] BYTE_DATA = 3'h4;
    localparam logic [2:0] BYTE_FAST_DATA = 3'h5;
    localparam logic [2:0] BYTE_SAT = 3'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Status register bit positions
    localparam int SR_WEL = 1;
    localparam int SR_BP0 = 2;
    localparam int SR_BP1 = 3;
    localparam int SR_QUAD = 6;
    localparam int SR_STATUS_WRITE_DISABLE_BIT = 7;

    // Reset values
    localparam logic [1:0] BP_RESET = 2'h0;
    localparam logic STATUS_WRITE_DISABLE_BIT_RESET = 1'b0;
    localparam logic QUAD_MODE_VALUE = 1'b0;

    // Timing
    localparam int SYS_CLK_MHZ = 50;
    localparam int SLEEP_ENTRY_DELAY_NS = 3000;
    localparam int WAKE_RECOVERY_DELAY_NS = 3000;
    localparam int SLEEP_ENTRY_CYCLES =
        (SLEEP_ENTRY_DELAY_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int WAKE_RECOVERY_CYCLES =
        (WAKE_RECOVERY_DELAY_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int TIMER_BITS = 16;

    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'b00,
        PWR_ENTERING = 2'b01,
        PWR_ASLEEP = 2'b10,
        PWR_WAKING = 2'b11
    } smspi_pwr_t;
endpackage

// ### smspi_sync.sv
`timescale 1ns/100ps
module smspi_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule

// ### smspi_core_assertions.sv
`timescale 1ns/100ps
module smspi_core_assertions
    import smspi_pkg::*;
#(
    parameter int SLEEP_CYCLES = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic spiClk,
    input wire logic spiCsN,
    input wire logic spiSoEn,
    input wire logic [7:0] statusByte,
    input wire logic writeEnableLatch,
    input wire logic sleeping,
    input wire logic regulatorsOn,
    input wire logic executeInPlace
);
    logic [5:0] bitCnt;
    logic [7:0] offCnt;
    // Serial edges in the frame; chip select high restarts the count
    always_ff @(posedge spiClk or posedge spiCsN) begin
        if (spiCsN) begin
            bitCnt <= 6'h00;
        end else if (bitCnt != 6'h3F) begin
            bitCnt <= bitCnt + 6'h01;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst || regulatorsOn) begin
            offCnt <= 8'h00;
        end else if (offCnt != 8'hFF) begin
            offCnt <= offCnt + 8'h01;
        end
    end
    welMirror_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        statusByte[SR_WEL] == writeEnableLatch) else $error("wel mirror");
    welReset_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(sys_rst) |-> !writeEnableLatch && regulatorsOn && !sleeping)
        else $error("reset state");
    welCommit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $changed(writeEnableLatch) |-> spiCsN && $past(spiCsN, 2))
        else $error("wel moved in frame");
    quadBit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        statusByte[SR_QUAD] == QUAD_MODE_VALUE) else $error("quad bit");
    sleepFreeze_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        sleeping && $past(sleeping) |-> $stable(writeEnableLatch)
        && $stable(executeInPlace)) else $error("command while asleep");
    sleepDelay_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(sleeping) |-> offCnt >= SLEEP_CYCLES - 1
        && offCnt <= SLEEP_CYCLES + 2) else $error("sleep delay");
    wakeOrder_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $fell(sleeping) |-> regulatorsOn) else $error("wake order");
    dataStart_a: assert property (@(posedge spiClk) disable iff (spiCsN)
        bitCnt < 6'h20 |-> !spiSoEn) else $error("early output");
endmodule

// ### smspi_host.sv
`timescale 1ns/100ps
module smspi_host (
    input wire logic sys_clk,
    output logic spiClk,
    output logic spiCsN,
    output logic spiSi,
    input wire logic spiSo
);
    initial begin
        spiClk = 1'b0;
        spiSi = 1'b0;
        // A select pulse with no clock clears the link side, which has
        // no other reset
        spiCsN = 1'b0;
        #1;
        spiCsN = 1'b1;
    end
    // 6 ns serial period; the clock rests at its idle level between
    // frames, low for mode 0 and high for mode 3
    task automatic xfer(input logic [63:0] tx, input int nb,
        input logic idle, output logic [63:0] rx);
        rx = 64'h0;
        spiClk = idle;
        #2;
        spiCsN = 1'b0;
        #3;
        for (int i = 0; i < nb * 8; i++) begin
            spiClk = 1'b0;
            spiSi = tx[63 - i];
            #3;
            spiClk = 1'b1;
            rx[63 - i] = spiSo;
            #3;
        end
        spiClk = idle;
        #4;
        spiCsN = 1'b1;
        spiSi = ~spiSi;
        // Gap lets the status commit cross before the next frame
        repeat (8) @(negedge sys_clk);
    endtask
endmodule

// ### tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import smspi_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wpN = 1'b1;
    logic spiClk, spiCsN, spiSi, spiSo, spiSoEn;
    logic [7:0] statusByte;
    logic writeEnableLatch, sleeping, regulatorsOn, executeInPlace;
    logic [63:0] rx;
    int error_cnt = 0;
    int n_compared = 0;
    always #10 sys_clk = ~sys_clk;
    smspi_core #(.SLEEP_CYCLES(8), .WAKE_CYCLES(8)) smspi_core_i (
        .sys_clk, .sys_rst, .spiClk, .spiCsN, .spiSi, .spiSo, .spiSoEn,
        .wpN, .statusByte, .writeEnableLatch, .sleeping, .regulatorsOn,
        .executeInPlace);
    smspi_host smspi_host_i (.sys_clk, .spiClk, .spiCsN, .spiSi, .spiSo);
    task check(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task xf(input logic [63:0] tx, input int nb);
        smspi_host_i.xfer(tx, nb, 1'b0, rx);
    endtask
    task end_of_test;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task t_reset;
        check("wel", writeEnableLatch, 1'b0);
        check("status", statusByte, 8'h00);
        check("power", {sleeping, regulatorsOn, executeInPlace}, 3'h2);
    endtask
    task t_latch;
        xf({CMD_WRITE_ENABLE, 56'h0}, 1);
        check("wel set", writeEnableLatch, 1'b1);
        xf({CMD_WRITE, 24'h000010, 16'h5566, 16'h0}, 6);
        xf({CMD_WRITE_DISABLE, 56'h0}, 1);
        check("wel clr", statusByte[SR_WEL], 1'b0);
        xf({CMD_WRITE, 24'h000010, 16'hAABB, 16'h0}, 6);
        xf({CMD_READ, 24'h000010, 32'h0}, 6);
        check("guarded", rx[31:16], 16'h5566);
    endtask
    task t_wrap;
        xf({CMD_WRITE_ENABLE, 56'h0}, 1);
        xf({CMD_WRITE, 24'hFFFFFF, 16'h1234, 16'h0}, 6);
        xf({CMD_READ, 24'h01FFFF, 32'h0}, 6);
        check("rd wrap", rx[31:16], 16'h1234);
        smspi_host_i.xfer({CMD_READ, 24'h01FFFF, 32'h0}, 6, 1'b1, rx);
        check("rd mode3", rx[31:16], 16'h1234);
        xf({CMD_FAST_READ, 24'h01FFFF, MODE_XIP_ENTER, 24'h0}, 7);
        check("fast rd", rx[23:8], 16'h1234);
        check("xip on", executeInPlace, 1'b1);
        xf({CMD_FAST_READ, 24'hFE0000, MODE_XIP_EXIT, 24'h0}, 7);
        check("xip off", executeInPlace, 1'b0);
        check("lo byte", rx[23:16], 8'h34);
    endtask
    task t_status;
        xf({CMD_STATUS_WRITE, 8'hFF, 48'h0}, 2);
        check("sr set", statusByte, 8'h8E);
        wpN = 1'b0;
        repeat (4) @(negedge sys_clk);
        xf({CMD_STATUS_WRITE, 56'h0}, 2);
        check("sr locked", statusByte, 8'h8E);
        wpN = 1'b1;
        repeat (4) @(negedge sys_clk);
        xf({CMD_STATUS_WRITE, 56'h0}, 2);
        check("sr clear", statusByte, 8'h02);
    endtask
    task t_sleep;
        xf({CMD_SLEEP, 56'h0}, 1);
        repeat (8) @(negedge sys_clk);
        check("asleep", {sleeping, regulatorsOn}, 2'h2);
        xf({CMD_WRITE_DISABLE, 56'h0}, 1);
        check("ignored", writeEnableLatch, 1'b1);
        xf({CMD_WAKE, 56'h0}, 1);
        check("woken", {sleeping, regulatorsOn}, 2'h1);
        repeat (8) @(negedge sys_clk);
        xf({CMD_WRITE_DISABLE, 56'h0}, 1);
        check("active", writeEnableLatch, 1'b0);
        xf({CMD_SLEEP, 56'h0}, 1);
        repeat (8) @(negedge sys_clk);
        xf({CMD_READ, 24'h000010, 32'h0}, 6);
        check("no read", rx[31:16], 16'h0000);
        sys_rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        check("cold up", {sleeping, regulatorsOn}, 2'h1);
        repeat (4) @(negedge sys_clk);
        xf({CMD_WRITE_ENABLE, 56'h0}, 1);
        check("awake", writeEnableLatch, 1'b1);
    endtask
    initial begin
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        t_reset;
        t_latch;
        t_wrap;
        t_status;
        t_sleep;
        end_of_test;
    end
    initial begin
        #100000;
        error_cnt++;
        end_of_test;
    end
endmodule
bind smspi_core smspi_core_assertions #(.SLEEP_CYCLES(SLEEP_CYCLES)) chk_i (
    .sys_clk, .sys_rst, .spiClk, .spiCsN, .spiSoEn, .statusByte,
    .writeEnableLatch, .sleeping, .regulatorsOn, .executeInPlace);
